// ==== fecc_ctrl.sv ====
// Host controller that runs full chip erase and status clearing on a flash device.
//
// Design decisions made here: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "fecc_defs.svh"
module fecc_ctrl #(
  parameter int PULSE_CYC = `FECC_PULSE_CYC,
  parameter int WAKE_CYC  = `FECC_WAKE_CYC
) (
  // Clock and reset.
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Flash pins.
  output logic             flash_ce_n,
  output logic             flash_we_n,
  output logic             flash_oe_n,
  output logic [7:0]       flash_dq_out,
  output logic             flash_dq_oe,
  input  wire logic [7:0]  flash_dq_in,
  output logic             powerdown_reset_pin,
  input  wire logic        ready_busy_pin,
  // Interrupt.
  output logic             irq
);
  // The counter is 16 bits wide and the read hold adds two cycles to the pulse count.
  if (PULSE_CYC < 1 || PULSE_CYC > 255 || WAKE_CYC < 1 || WAKE_CYC > 65535) begin : g_bad_timing
    $error("fecc_ctrl: timing count out of range");
  end

  fecc_pkg::fecc_state_type st_ff, nxt_st;
  fecc_pkg::fecc_bus_type   bus_ff, nxt_bus;
  logic [15:0] cnt_ff, nxt_cnt;
  logic [1:0]  step_ff, nxt_step;
  logic        clr_op_ff, nxt_clr_op;
  logic [7:0]  sr_ff, nxt_sr;
  logic [2:0]  ist_ff, nxt_ist, ien_ff, nxt_ien;
  logic        pd_ff, nxt_pd, pd_n_ff;
  logic [31:0] prdata_ff, nxt_prdata;
  logic        pready_ff, nxt_pready, pslverr_ff, nxt_pslverr;
  logic        irq_ff;
  logic [7:0]  dq_s1_ff, dq_s2_ff;
  logic        rb_s1_ff, rb_s2_ff;
  logic        start_req, clear_req;
  logic [2:0]  ev;

  // Pin inputs pass two flip-flops before use.
  always_ff @(posedge ref_clk) begin
    dq_s1_ff <= flash_dq_in;
    dq_s2_ff <= dq_s1_ff;
    rb_s1_ff <= ready_busy_pin;
    rb_s2_ff <= rb_s1_ff;
  end

  function automatic logic [7:0] cmd_of(input logic [1:0] step, input logic clr);
    if (clr) begin
      cmd_of = (step == 2'd0) ? `FECC_CMD_CLEAR_STATUS : `FECC_CMD_READ_ARRAY;
    end else begin
      case (step)
        2'd0:    cmd_of = `FECC_CMD_READ_STATUS;
        2'd1:    cmd_of = `FECC_CMD_ERASE_SETUP;
        2'd2:    cmd_of = `FECC_CMD_ERASE_CONFIRM;
        default: cmd_of = `FECC_CMD_READ_ARRAY;
      endcase
    end
  endfunction

  wire apb_acc = psel && penable && !pready_ff;
  wire apb_wr  = apb_acc && pwrite;
  assign start_req = apb_wr && paddr == `FECC_REG_CTRL && pwdata[`FECC_CTRL_START];
  assign clear_req = apb_wr && paddr == `FECC_REG_CTRL && pwdata[`FECC_CTRL_CLEAR];

  // Sequencer of the flash pins.
  always_comb begin
    nxt_st = st_ff;
    nxt_bus = bus_ff;
    nxt_cnt = cnt_ff;
    nxt_step = step_ff;
    nxt_clr_op = clr_op_ff;
    nxt_sr = sr_ff;
    nxt_pd = pd_ff;
    ev = 3'h0;
    case (st_ff)
      fecc_pkg::ST_IDLE: begin
        nxt_bus = '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, dq_out: 8'h00, dq_oe: 1'b0};
        if (apb_wr && paddr == `FECC_REG_CTRL && pwdata[`FECC_CTRL_PDOWN]) begin
          nxt_pd = 1'b1; // RL16
          nxt_sr = 8'h00; // RL11
          nxt_st = fecc_pkg::ST_PDOWN;
        end else if (start_req || clear_req) begin
          nxt_clr_op = clear_req && !start_req;
          nxt_step = 2'd0; // RL1 RL10
          nxt_st = fecc_pkg::ST_WRCMD;
        end
      end
      fecc_pkg::ST_WRCMD: begin
        // Both enables low together form the command write; the rising edge latches it.
        nxt_bus = '{ce_n: 1'b0, we_n: 1'b0, oe_n: 1'b1, // RL17
                    dq_out: cmd_of(step_ff, clr_op_ff), dq_oe: 1'b1};
        nxt_cnt = 16'(PULSE_CYC);
        nxt_st = fecc_pkg::ST_WRREC;
      end
      fecc_pkg::ST_WRREC: begin
        nxt_cnt = cnt_ff - 16'h1;
        if (cnt_ff == 16'h1) begin
          nxt_bus.we_n = 1'b1;
          nxt_bus.ce_n = 1'b1;
          nxt_cnt = 16'(PULSE_CYC);
          nxt_st = fecc_pkg::ST_PAUSE;
        end
      end
      fecc_pkg::ST_PAUSE: begin
        nxt_bus.dq_oe = 1'b0;
        nxt_cnt = cnt_ff - 16'h1;
        if (cnt_ff == 16'h1) begin
          if (clr_op_ff) begin
            // Clear then array read; the error bits are gone only after this.
            nxt_step = step_ff + 2'd1;
            if (step_ff == 2'd0) begin
              nxt_sr = 8'h80; // RL5
              nxt_st = fecc_pkg::ST_WRCMD;
            end else begin
              nxt_st = fecc_pkg::ST_IDLE;
            end
          end else if (step_ff == 2'd1) begin
            nxt_step = 2'd2;
            nxt_st = fecc_pkg::ST_WRCMD; // RL1
          end else if (step_ff == 2'd3) begin
            nxt_st = fecc_pkg::ST_IDLE; // RL14
          end else begin
            nxt_st = fecc_pkg::ST_RDST;
          end
        end
      end
      fecc_pkg::ST_RDST: begin
        nxt_bus = '{ce_n: 1'b0, we_n: 1'b1, oe_n: 1'b0, dq_out: 8'h00, dq_oe: 1'b0};
        nxt_cnt = 16'(PULSE_CYC) + 16'h2;
        nxt_st = fecc_pkg::ST_RDHLD;
      end
      fecc_pkg::ST_RDHLD: begin
        nxt_cnt = cnt_ff - 16'h1;
        if (cnt_ff == 16'h1) begin
          nxt_sr = dq_s2_ff;
          nxt_bus.oe_n = 1'b1;
          nxt_bus.ce_n = 1'b1;
          nxt_st = fecc_pkg::ST_DECIDE;
        end
      end
      fecc_pkg::ST_DECIDE: begin
        // Pin low means busy; the ready bit must agree before moving on.
        if (!sr_ff[`FECC_SR_READY] || !rb_s2_ff) begin // RL19 RL6
          nxt_st = fecc_pkg::ST_RDST;
        end else begin
          if (step_ff == 2'd2) begin
            ev[`FECC_EV_DONE] = 1'b1;
            if (sr_ff[`FECC_SR_ERASE_ERR] || sr_ff[`FECC_SR_WRITE_ERR]
                || sr_ff[`FECC_SR_SUPPLY_ERR]) begin // RL2 RL3 RL4
              ev[`FECC_EV_ERROR] = 1'b1;
            end
          end
          nxt_step = step_ff + 2'd1;
          nxt_st = fecc_pkg::ST_WRCMD;
        end
      end
      fecc_pkg::ST_PDOWN: begin
        nxt_bus = '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, dq_out: 8'h00, dq_oe: 1'b0}; // RL18
        if (apb_wr && paddr == `FECC_REG_CTRL && !pwdata[`FECC_CTRL_PDOWN]) begin
          nxt_pd = 1'b0;
          nxt_cnt = 16'(WAKE_CYC);
          nxt_st = fecc_pkg::ST_WAKE;
        end
      end
      fecc_pkg::ST_WAKE: begin
        nxt_cnt = cnt_ff - 16'h1;
        if (cnt_ff == 16'h1) begin
          nxt_st = fecc_pkg::ST_IDLE; // RL13
        end
      end
      default: nxt_st = fecc_pkg::ST_IDLE;
    endcase
    // An abort by powerdown drops the sequence; software restarts it in full.
    if (pd_ff == 1'b0 && nxt_pd && st_ff != fecc_pkg::ST_IDLE) begin
      ev[`FECC_EV_ABORT] = 1'b1; // RL9
    end
    if (apb_wr && paddr == `FECC_REG_CTRL && pwdata[`FECC_CTRL_PDOWN]
        && st_ff != fecc_pkg::ST_IDLE && st_ff != fecc_pkg::ST_PDOWN) begin
      nxt_pd = 1'b1;
      nxt_sr = 8'h00; // RL11
      ev[`FECC_EV_ABORT] = 1'b1; // RL9 RL10
      nxt_bus = '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, dq_out: 8'h00, dq_oe: 1'b0};
      nxt_st = fecc_pkg::ST_PDOWN;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_ff     <= fecc_pkg::ST_IDLE;
      bus_ff    <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, dq_out: 8'h00, dq_oe: 1'b0};
      cnt_ff    <= 16'h0;
      step_ff   <= 2'd0;
      clr_op_ff <= 1'b0;
      sr_ff     <= 8'h80;
      pd_ff     <= 1'b1;
      pd_n_ff   <= 1'b0;
    end else begin
      st_ff     <= (st_ff == fecc_pkg::ST_IDLE && pd_ff) ? fecc_pkg::ST_PDOWN : nxt_st;
      bus_ff    <= nxt_bus;
      cnt_ff    <= nxt_cnt;
      step_ff   <= nxt_step;
      clr_op_ff <= nxt_clr_op;
      sr_ff     <= nxt_sr;
      pd_ff     <= nxt_pd;
      pd_n_ff   <= !nxt_pd; // RL16
    end
  end

  // APB registers and interrupt; a new event wins over a clear in the same cycle.
  always_comb begin
    nxt_ien = ien_ff;
    nxt_ist = ist_ff;
    nxt_prdata = prdata_ff;
    nxt_pslverr = 1'b0;
    nxt_pready = apb_acc;
    if (apb_wr && paddr == `FECC_REG_IRQ_CLR) begin
      nxt_ist = ist_ff & ~pwdata[2:0];
    end
    nxt_ist = nxt_ist | ev;
    if (apb_wr && paddr == `FECC_REG_IRQ_EN) begin
      nxt_ien = pwdata[2:0];
    end
    if (apb_acc) begin
      case (paddr)
        `FECC_REG_CTRL:     nxt_prdata = {29'h0, pd_ff, 1'b0, st_ff != fecc_pkg::ST_IDLE};
        `FECC_REG_STATUS:   nxt_prdata = {23'h0, rb_s2_ff, sr_ff};
        `FECC_REG_IRQ_STAT: nxt_prdata = {29'h0, ist_ff};
        `FECC_REG_IRQ_CLR:  nxt_prdata = 32'h0;
        `FECC_REG_IRQ_EN:   nxt_prdata = {29'h0, ien_ff};
        default: begin
          nxt_prdata = 32'h0;
          nxt_pslverr = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ien_ff     <= 3'h0;
      ist_ff     <= 3'h0;
      prdata_ff  <= 32'h0;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      irq_ff     <= 1'b0;
    end else begin
      ien_ff     <= nxt_ien;
      ist_ff     <= nxt_ist;
      prdata_ff  <= nxt_prdata;
      pready_ff  <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      irq_ff     <= |(nxt_ist & nxt_ien);
    end
  end

  assign prdata              = prdata_ff;
  assign pready              = pready_ff;
  assign pslverr             = pslverr_ff;
  assign irq                 = irq_ff;
  assign flash_ce_n          = bus_ff.ce_n;
  assign flash_we_n          = bus_ff.we_n;
  assign flash_oe_n          = bus_ff.oe_n;
  assign flash_dq_out        = bus_ff.dq_out;
  assign flash_dq_oe         = bus_ff.dq_oe;
  assign powerdown_reset_pin = pd_n_ff;

  a_cmd_write_enables: assert property (@(posedge ref_clk) disable iff (rst)
    !flash_we_n |-> !flash_ce_n && flash_dq_oe && flash_oe_n) else $error("we low without ce"); // RL17
  a_pd_disables_bus: assert property (@(posedge ref_clk) disable iff (rst)
    !powerdown_reset_pin && $past(!powerdown_reset_pin) |-> flash_ce_n && flash_we_n)
    else $error("bus active in powerdown"); // RL18
  a_pd_clears_status: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(pd_ff) |-> sr_ff == 8'h00) else $error("status not cleared"); // RL11
  a_confirm_after_setup: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(flash_we_n) && flash_dq_out == `FECC_CMD_ERASE_CONFIRM |->
    $past(step_ff) == 2'd2 && !clr_op_ff) else $error("confirm out of order"); // RL1
  a_done_needs_ready: assert property (@(posedge ref_clk) disable iff (rst)
    ev[`FECC_EV_DONE] |-> sr_ff[`FECC_SR_READY] && rb_s2_ff) else $error("done while busy"); // RL19
  a_abort_flags_event: assert property (@(posedge ref_clk) disable iff (rst)
    ev[`FECC_EV_ABORT] |=> ist_ff[`FECC_EV_ABORT] && !powerdown_reset_pin)
    else $error("abort not flagged"); // RL9
  a_irq_level: assert property (@(posedge ref_clk) disable iff (rst)
    irq == |(ist_ff & ien_ff)) else $error("irq mismatch");
  a_apb_one_wait: assert property (@(posedge ref_clk) disable iff (rst)
    psel && penable && !pready |=> pready) else $error("apb answer late");
endmodule // fecc_ctrl

// ==== fecc_ctrl_bench.sv ====
// Self-checking bench for the flash full-erase host controller.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin err_count++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module fecc_ctrl_bench;
  typedef struct {string nm; logic [31:0] e; logic [31:0] m; logic er;} fecc_note_type;
  logic          ref_clk = 1'b0;
  logic          rst = 1'b1;
  logic          psel = 1'b0;
  logic          penable = 1'b0;
  logic          pwrite = 1'b0;
  logic [11:0]   paddr = 12'h000;
  logic [31:0]   pwdata = 32'h0;
  logic [1:0]    err_mode = 2'h0;
  logic [15:0]   busy_cyc = 16'h0028;
  logic [31:0]   prdata, rd;
  logic [7:0]    dq_out, dq_rd, dq_bus;
  logic          pready, pslverr, ce_n, we_n, oe_n, dq_oe, pd_n, rb_low, irq;
  logic [7:0]    exp_sr [4] = '{8'h80, 8'ha0, 8'ha8, 8'hb0};
  int            err_count = 0;
  int            tests_run = 0;
  int            cyc = 0;
  fecc_note_type notes[$];
  fecc_note_type n;

  assign dq_bus = dq_oe ? dq_out : dq_rd;
  initial forever #10 ref_clk = ~ref_clk;

  fecc_ctrl #(.PULSE_CYC(1), .WAKE_CYC(2)) DUT (
    .ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flash_ce_n(ce_n), .flash_we_n(we_n), .flash_oe_n(oe_n), .flash_dq_out(dq_out),
    .flash_dq_oe(dq_oe), .flash_dq_in(dq_bus), .powerdown_reset_pin(pd_n),
    .ready_busy_pin(~rb_low), .irq(irq));
  fecc_flash_model FLASH (
    .ref_clk(ref_clk), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n), .dq_wr(dq_bus), .pd_n(pd_n),
    .dq_rd(dq_rd), .rb_pull_low(rb_low), .err_mode(err_mode), .busy_cyc(busy_cyc));

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Every answer is judged here, in the order the requests were made.
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc > 60000) begin
      err_count++;
      print_verdict();
    end else if (pready === 1'b1) begin
      n = notes.pop_front();
      `CHK(n.nm, n.e & n.m, prdata & n.m)
      `CHK(n.nm, n.er, pslverr)
    end
  end

  // One idle cycle after each transfer keeps psel from being driven twice in a step.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] e, input logic [31:0] m, input logic er,
                     input string nm);
    int k;
    notes.push_back('{nm, e, m, er});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) err_count++;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 32'h0, 1'b0, "write");
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m,
                     input string nm);
    apb(1'b0, a, 32'h0, e, m, 1'b0, nm);
  endtask

  task automatic start_erase(input logic see_busy);
    int k;
    wr(12'h000, ($urandom() & 32'hffff_fff8) | 32'h1);
    k = 0;
    while (see_busy && rb_low !== 1'b1 && k < 400) begin
      @(posedge ref_clk);
      k++;
    end
    if (see_busy && k >= 400) err_count++;
    if (see_busy) rdc(12'h004, 32'h0, 32'h100, "pin_busy");
  endtask

  task automatic wait_idle();
    int k;
    k = 0;
    do begin
      rdc(12'h000, 32'h0, 32'h0, "poll");
      k++;
    end while (rd[0] !== 1'b0 && k < 600);
    if (k >= 600) err_count++;
  endtask

  initial begin
    void'($urandom(32'h2020));
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    `CHK("pd_pin", 1'b0, pd_n)
    rdc(12'h000, 32'h5, 32'h5, "ctrl_rst");
    apb(1'b0, 12'h020, 32'h0, 32'h0, 32'h0, 1'b1, "unmapped");
    wr(12'h000, 32'h0);
    repeat (6) @(posedge ref_clk);
    wr(12'h010, 32'h7);
    rdc(12'h010, 32'h7, 32'h7, "irq_en");
    for (int i = 0; i < 4; i++) begin
      err_mode <= i[1:0];
      busy_cyc <= 16'(40 + $urandom_range(200));
      start_erase(i != 3);
      wait_idle();
      rdc(12'h004, {23'h0, 1'b1, exp_sr[i]}, 32'h1ff, "status");
      rdc(12'h008, (i == 0) ? 32'h1 : 32'h3, 32'h3, "irq_stat");
      `CHK("irq_set", 1'b1, irq)
      wr(12'h00c, 32'h7);
      wr(12'h000, 32'h2);
      wait_idle();
      repeat (2) @(posedge ref_clk);
      `CHK("irq_clr", 1'b0, irq)
    end
    err_mode <= 2'h1;
    start_erase(1'b1);
    wait_idle();
    err_mode <= 2'h0;
    start_erase(1'b1);
    wait_idle();
    rdc(12'h004, 32'h1a0, 32'h1ff, "sticky");
    wr(12'h000, 32'h2);
    wait_idle();
    start_erase(1'b1);
    wait_idle();
    rdc(12'h004, 32'h180, 32'h1ff, "cleared");
    wr(12'h00c, 32'h7);
    wr(12'h010, 32'h3);
    busy_cyc <= 16'h0258;
    start_erase(1'b1);
    wr(12'h000, 32'h4);
    repeat (4) @(posedge ref_clk);
    rdc(12'h008, 32'h4, 32'h4, "abort");
    `CHK("irq_mask", 1'b0, irq)
    rdc(12'h004, 32'h100, 32'h1ff, "status_pd");
    wr(12'h000, 32'h0);
    repeat (6) @(posedge ref_clk);
    start_erase(1'b1);
    wait_idle();
    rdc(12'h004, 32'h180, 32'h1ff, "reissue");
    print_verdict();
  end
endmodule // fecc_ctrl_bench

// ==== fecc_defs.svh ====
// Constants of the flash full-erase host controller.
// Contract
// RL1: Erase: write 70H, wait ready, write 30H then D0H, poll until ready.
// RL2: Invalid command sequence sets erase-error and write-error bits together.
// RL3: Failed full chip erase sets the erase-error bit.
// RL4: Supply out of range sets supply-error plus erase or write error.
// RL5: Error bits are sticky; only the clear-status command clears them.
// RL6: Ready/busy pin goes low on accepted operation, released when finished.
// RL7: Ready/busy pin floats during suspend and deep power-down.
// RL8: Ready/busy pin reflects internal state regardless of chip select.
// RL9: Powerdown during operation holds busy, aborts, enters deep power-down.
// RL10: After a reset abort the host reissues the whole command sequence.
// RL11: Powerdown low or power loss clears the whole status register.
// RL12: Command interface state survives supply, chip-enable and machine activity.
// RL13: Command interface enters array read at power-up and powerdown exit.
// RL14: Host issues array-read command after any operation before array reads.
// RL15: Results are not guaranteed with bad supplies or powerdown low.
// RL16: Drive the powerdown pin from system power-good, toggling on reset; the code drives it from the CTRL powerdown bit, which reset sets.
// RL17: Command writes happen only while chip-enable and write-enable are low.
// RL18: Device is disabled while powerdown is low, whatever other inputs do.
// RL19: Ready bit reads one when idle, zero while an operation runs.
`ifndef FECC_DEFS_SVH
`define FECC_DEFS_SVH
`define FECC_CMD_READ_STATUS   8'h70
`define FECC_CMD_ERASE_SETUP   8'h30
`define FECC_CMD_ERASE_CONFIRM 8'hd0
`define FECC_CMD_CLEAR_STATUS  8'h50
`define FECC_CMD_READ_ARRAY    8'hff
`define FECC_SR_READY          7
`define FECC_SR_ERASE_ERR      5
`define FECC_SR_WRITE_ERR      4
`define FECC_SR_SUPPLY_ERR     3
`define FECC_SR_LOCK_ERR       1
`define FECC_REG_CTRL          12'h000
`define FECC_REG_STATUS        12'h004
`define FECC_REG_IRQ_STAT      12'h008
`define FECC_REG_IRQ_CLR       12'h00c
`define FECC_REG_IRQ_EN        12'h010
`define FECC_CTRL_START        0
`define FECC_CTRL_CLEAR        1
`define FECC_CTRL_PDOWN        2
`define FECC_PULSE_NS          100
`define FECC_PULSE_CYC         ((`FECC_PULSE_NS + 19) / 20)
`define FECC_WAKE_NS           1000
`define FECC_WAKE_CYC          ((`FECC_WAKE_NS + 19) / 20)
`define FECC_EV_DONE           0
`define FECC_EV_ERROR          1
`define FECC_EV_ABORT          2
`endif

// ==== fecc_flash_model.sv ====
// Behavioural model of the flash device seen by the full-erase controller.
`timescale 1ns/1ps
module fecc_flash_model (
  // Timing reference.
  input  wire logic        ref_clk,
  // Device pins.
  input  wire logic        ce_n,
  input  wire logic        we_n,
  input  wire logic        oe_n,
  input  wire logic [7:0]  dq_wr,
  input  wire logic        pd_n,
  output logic [7:0]       dq_rd,
  output logic             rb_pull_low,
  // Scenario knobs: 1 erase fails, 2 supply bad, 3 confirm seen as invalid.
  input  wire logic [1:0]  err_mode,
  input  wire logic [15:0] busy_cyc
);
  logic [7:0] cmd_q;
  logic [7:0] sr;
  logic [7:0] last = 8'h00;
  logic       armed = 1'b0;
  logic       setup = 1'b0;
  logic       stat_mode = 1'b0;
  int         cnt = 0;

  // Open drain: only pulls low while the erase runs, floats otherwise.
  assign rb_pull_low = pd_n && (cnt > 0);
  // An undriven bus toggles so that a stale value never passes as data.
  assign dq_rd = (!ce_n && !oe_n && pd_n) ? (stat_mode ? sr : 8'hff) : ~last;

  always @(posedge ref_clk) begin
    last <= dq_rd;
    if (!pd_n) begin
      sr <= 8'h80;
      armed <= 1'b0;
      setup <= 1'b0;
      stat_mode <= 1'b0;
      cnt <= 0;
    end else begin
      if (cnt > 0) cnt <= cnt - 1;
      if (cnt == 1) begin
        sr[7] <= 1'b1;
        if (err_mode == 2'h1) sr[5] <= 1'b1;
        if (err_mode == 2'h2) begin
          sr[5] <= 1'b1;
          sr[3] <= 1'b1;
        end
      end
      if (!ce_n && !we_n) begin
        cmd_q <= dq_wr;
        armed <= 1'b1;
      end else if (armed) begin
        armed <= 1'b0;
        stat_mode <= (cmd_q != 8'hff);
        setup <= (cmd_q == 8'h30);
        if (cmd_q == 8'h50) sr[5:1] <= 5'h00;
        if (setup && cmd_q == 8'hd0 && err_mode != 2'h3) begin
          sr[7] <= 1'b0;
          cnt <= int'(busy_cyc);
        end else if (setup) sr[5:4] <= 2'h3;
      end
    end
  end
endmodule // fecc_flash_model

// ==== fecc_pkg.sv ====
// Types of the flash full-erase host controller.
package fecc_pkg;
  typedef enum logic [8:0] {
    ST_IDLE  = 9'h001,
    ST_WRCMD = 9'h002,
    ST_WRREC = 9'h004,
    ST_RDST  = 9'h008,
    ST_RDHLD = 9'h010,
    ST_DECIDE= 9'h020,
    ST_PDOWN = 9'h040,
    ST_WAKE  = 9'h080,
    ST_PAUSE = 9'h100
  } fecc_state_type;
  typedef struct packed {
    logic       ce_n;
    logic       we_n;
    logic       oe_n;
    logic [7:0] dq_out;
    logic       dq_oe;
  } fecc_bus_type;
endpackage
